// File: dol_pkg.sv
// Package of constants and carrier types for the digital output logic block.
package dol_pkg;

	// -----------------------------------------------------------------
	// Configuration codes
	// -----------------------------------------------------------------
	localparam logic [15:0] OUTPUT_TYPE_DIGITAL = 16'h03e8;
	localparam logic [3:0] CONTROL_SOURCE_NETWORK = 4'h1;
	localparam logic [1:0] POL_NORMAL = 2'h0;
	localparam logic [1:0] POL_INVERSE = 2'h1;
	localparam logic [1:0] POL_LATCHED = 2'h2;
	localparam logic [1:0] POL_BLINK = 2'h3;
	localparam logic FAULT_MODE_KEEP = 1'h0;
	localparam logic FAULT_MODE_PREDEFINED = 1'h1;
	localparam logic FAULT_MODE_RESET = FAULT_MODE_PREDEFINED;
	localparam logic ON_LEVEL_5V = 1'h0;
	localparam logic ON_LEVEL_12V = 1'h1;

	// -----------------------------------------------------------------
	// Timing and sizes
	// -----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int CONTROL_WIDTH = 16;
	localparam int SUBINDEX_COUNT = 3;

	// -----------------------------------------------------------------
	// Carrier types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] output_type_select;
		logic [3:0] control_source_select;
		logic [1:0] control_number;
		logic [1:0] polarity;
		logic [15:0] blink_rate_ms;
		logic fault_mode;
		logic fault_state;
		logic on_level_select;
		logic analog_control;
		logic [15:0] control_min;
		logic [15:0] control_max;
	} dol_cfg_s;

	typedef struct packed {
		logic control_fault;
		logic enable_fault;
		logic override_fault;
		logic override_active;
		logic override_value;
		logic enable;
	} dol_gate_s;

endpackage

// File: dol_blink.sv
// Blink timer: millisecond tick and half-period toggle.
`timescale 1ns/1ps
module dol_blink #(
	parameter int TICK_CYCLES = 40000
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Control
	input wire logic i_run,
	input wire logic [15:0] i_rate_ms,
	// Output
	output logic o_phase
);
	import dol_pkg::*;

	typedef struct packed {
		logic [15:0] tick_cnt;
		logic [15:0] ms_cnt;
		logic phase;
		logic run;
	} dol_blink_state_s;

	dol_blink_state_s st;
	dol_blink_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.run = i_run;
		if (!i_run || !st.run) begin
			// Restarting on every blink start keeps the first ON interval full length.
			next_st.tick_cnt = 16'h0000;
			next_st.ms_cnt = 16'h0000;
			next_st.phase = i_run;
		end else if (st.tick_cnt == 16'(TICK_CYCLES - 1)) begin
			next_st.tick_cnt = 16'h0000;
			if (st.ms_cnt + 16'h0001 >= i_rate_ms) begin
				next_st.ms_cnt = 16'h0000;
				next_st.phase = !st.phase;
			end else begin
				next_st.ms_cnt = st.ms_cnt + 16'h0001;
			end
		end else begin
			next_st.tick_cnt = st.tick_cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_phase = st.phase;
endmodule

// File: dol_output.sv
// Digital on/off output logic for one universal output pin.
//
// Behaviour
// - Logic drives the pin only while output type selects digital on/off.
// - Network source takes the control value from the matching write-state sub-index.
// - Output follows control only without faults, override and disable.
// - Control zero gives logic OFF, any non-zero value gives logic ON.
// - Polarity 0 passes state, polarity 1 inverts it; 0 is default.
// - Polarity 2 toggles drive on each OFF-to-ON logic edge only.
// - Polarity 3 blinks drive while logic ON, holds OFF while logic OFF.
// - Feedback shows drive state, 0 OFF and 1 ON, for digital type.
// - On-level select picks the 5 V or 12 V ON level.
// - Analog control: OFF at or below min, ON at or above max, else hold.
// - Fault response applies when control, enable or override report errors.
// - Fault mode 0 keeps last drive; mode 1 forces predefined fault state.
// - After reset the fault mode applies the predefined fault state.
`timescale 1ns/1ps
module dol_output #(
	parameter int TICK_CYCLES = dol_pkg::TICK_CYCLES
) (
	// Clock, reset and enable
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Configuration
	input wire dol_pkg::dol_cfg_s i_cfg,
	input wire logic i_fault_mode_write,
	// Control values
	input wire logic [dol_pkg::SUBINDEX_COUNT-1:0] i_write_state,
	input wire logic [15:0] i_block_value,
	// Gating inputs
	input wire dol_pkg::dol_gate_s i_gate,
	// Pin drive
	output logic o_drive_active,
	output logic o_drive_on,
	output logic o_level_12v,
	// Status
	output logic o_drive_state_feedback,
	output logic o_fault_active
);
	import dol_pkg::*;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic cmd_state;
		logic logic_prev;
		logic drive;
		logic fault_mode;
		logic drive_active;
		logic drive_on;
		logic level_12v;
		logic feedback;
		logic fault_active;
	} dol_state_s;

	dol_state_s st;
	dol_state_s next_st;
	logic blink_phase;
	logic digital;
	logic network_bit;
	logic faulted;
	logic follow;
	logic logic_state;
	logic polar_drive;

	function automatic logic dol_select_bit(input logic [SUBINDEX_COUNT-1:0] bits, input logic [1:0] num);
		dol_select_bit = 1'b0;
		if (num != 2'h0 && 32'(num) <= SUBINDEX_COUNT) begin
			dol_select_bit = bits[num - 2'h1];
		end
	endfunction

	// -----------------------------------------------------------------
	// Blink timer
	// -----------------------------------------------------------------
	dol_blink #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_blink (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_run(digital && i_cfg.polarity == POL_BLINK && logic_state),
		.i_rate_ms(i_cfg.blink_rate_ms),
		.o_phase(blink_phase)
	);

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	always_comb begin
		next_st = st;
		digital = (i_cfg.output_type_select == OUTPUT_TYPE_DIGITAL);
		network_bit = dol_select_bit(i_write_state, i_cfg.control_number);
		faulted = i_gate.control_fault || i_gate.enable_fault || i_gate.override_fault;

		// Command state from the selected control source.
		if (i_cfg.analog_control) begin
			if (i_block_value <= i_cfg.control_min) begin
				next_st.cmd_state = 1'b0;
			end else if (i_block_value >= i_cfg.control_max) begin
				next_st.cmd_state = 1'b1;
			end
		end else if (i_cfg.control_source_select == CONTROL_SOURCE_NETWORK) begin
			next_st.cmd_state = network_bit;
		end else begin
			next_st.cmd_state = (i_block_value != 16'h0000);
		end

		// Override beats enable, and a disabled output rests OFF.
		follow = !faulted && !i_gate.override_active && i_gate.enable;
		if (i_gate.override_active) begin
			logic_state = i_gate.override_value;
		end else if (!i_gate.enable) begin
			logic_state = 1'b0;
		end else begin
			logic_state = st.cmd_state;
		end
		next_st.logic_prev = logic_state;

		polar_drive = st.drive;
		case (i_cfg.polarity)
			POL_NORMAL: begin
				polar_drive = logic_state;
			end
			POL_INVERSE: begin
				polar_drive = !logic_state;
			end
			POL_LATCHED: begin
				if (logic_state && !st.logic_prev) begin
					polar_drive = !st.drive;
				end
			end
			default: begin
				polar_drive = logic_state && blink_phase;
			end
		endcase

		if (i_fault_mode_write) begin
			next_st.fault_mode = i_cfg.fault_mode;
		end
		if (!digital) begin
			next_st.drive = 1'b0;
		end else if (faulted) begin
			if (st.fault_mode == FAULT_MODE_PREDEFINED) begin
				next_st.drive = i_cfg.fault_state;
			end
		end else if (follow || i_gate.override_active || !i_gate.enable) begin
			next_st.drive = polar_drive;
		end

		next_st.drive_active = digital;
		next_st.drive_on = digital && next_st.drive;
		next_st.level_12v = (i_cfg.on_level_select == ON_LEVEL_12V);
		next_st.feedback = digital && next_st.drive;
		next_st.fault_active = digital && faulted;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.fault_mode <= FAULT_MODE_RESET;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign o_drive_active = st.drive_active;
	assign o_drive_on = st.drive_on;
	assign o_level_12v = st.level_12v;
	assign o_drive_state_feedback = st.feedback;
	assign o_fault_active = st.fault_active;
endmodule

// File: dol_partner.sv
// Model of the network master and on-board block feeding the output.
`timescale 1ns/1ps
module dol_partner (
	// Clock and pace
	input wire logic i_ref_clk,
	input wire logic i_slow,
	// Value to send
	input wire logic [15:0] i_value,
	// Values seen by the output
	output logic [15:0] o_block_value = 16'h0,
	output logic [2:0] o_write_state = 3'h0
);
	logic hold = 1'b0;
	// A slow sender refreshes its process data only every other cycle.
	always @(posedge i_ref_clk) begin
		hold <= i_slow && !hold;
		if (!hold) begin
			o_block_value <= i_value;
			o_write_state <= i_value[2:0];
		end
	end
endmodule

// File: dol_output_sva.sv
// Port checker for the digital output block.
`timescale 1ns/1ps
module dol_sva (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Inputs
	input wire dol_pkg::dol_cfg_s i_cfg,
	input wire logic i_fault_mode_write,
	input wire logic [2:0] i_write_state,
	input wire logic [15:0] i_block_value,
	input wire dol_pkg::dol_gate_s i_gate,
	// Outputs
	input wire logic o_drive_active,
	input wire logic o_drive_on,
	input wire logic o_level_12v,
	input wire logic o_drive_state_feedback,
	input wire logic o_fault_active
);
	import dol_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic d, f, nv, lv, fw;
	assign d = i_ce && i_cfg.output_type_select == OUTPUT_TYPE_DIGITAL;
	assign f = i_gate.control_fault || i_gate.enable_fault || i_gate.override_fault;
	assign nv = d && !f && !i_gate.override_active && i_gate.enable && !i_cfg.analog_control
		&& !i_cfg.polarity[1] && i_cfg.control_source_select != CONTROL_SOURCE_NETWORK;
	assign lv = (i_block_value != 16'h0) ^ i_cfg.polarity[0];
	assign fw = d && f && i_fault_mode_write;
	AST_TYPE_OFF: assert property (i_ce && !d |=> !o_drive_active && !o_drive_on)
		else $error("drive outside digital type");
	AST_TYPE_ON: assert property (d |=> o_drive_active)
		else $error("digital type not driven");
	AST_FEEDBACK: assert property (o_drive_state_feedback == o_drive_on)
		else $error("feedback differs");
	AST_LEVEL: assert property (i_ce |=> o_level_12v == $past(i_cfg.on_level_select))
		else $error("wrong on level");
	AST_FAULT: assert property (d && f |=> o_fault_active)
		else $error("fault not flagged");
	AST_FOLLOW: assert property ((nv && $stable(lv)) [*3] |-> o_drive_on == lv)
		else $error("drive not following control");
	AST_PREDEF: assert property ((fw && i_cfg.fault_mode) [*2] |=> o_drive_on == $past(i_cfg.fault_state))
		else $error("fault state not applied");
	AST_KEEP: assert property ((fw && !i_cfg.fault_mode) [*2] |=> $stable(o_drive_on))
		else $error("drive changed in fault");
	cover property (fw [*2]);
	cover property (nv [*3] ##1 !o_drive_on);
	cover property ($rose(o_fault_active));
endmodule
bind dol_output dol_sva u_sva (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_ce(i_ce),
	.i_cfg(i_cfg),
	.i_fault_mode_write(i_fault_mode_write),
	.i_write_state(i_write_state),
	.i_block_value(i_block_value),
	.i_gate(i_gate),
	.o_drive_active(o_drive_active),
	.o_drive_on(o_drive_on),
	.o_level_12v(o_level_12v),
	.o_drive_state_feedback(o_drive_state_feedback),
	.o_fault_active(o_fault_active)
);

// File: test_digital_output_logic_block.sv
// Bench for the digital output block.
`timescale 1ns/1ps
module test_digital_output_logic_block;
	import dol_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fmw = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [15:0] val = 16'h0;
	logic [15:0] blk;
	logic [2:0] ws;
	logic act, on, lvl, fb, fa;
	dol_cfg_s b = '{output_type_select: OUTPUT_TYPE_DIGITAL, polarity: POL_LATCHED, default: '0};
	dol_cfg_s cfg = '0;
	dol_gate_s g = '{enable: 1'b1, default: 1'b0};
	dol_gate_s gate = '0;
	int error_cnt = 0;
	int n_tests = 0;
	int n;
	always #12.5 clk = !clk;
	dol_partner host (.i_ref_clk(clk), .i_slow(slow), .i_value(val), .o_block_value(blk), .o_write_state(ws));
	dol_output #(.TICK_CYCLES(4)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cfg(cfg),
		.i_fault_mode_write(fmw), .i_write_state(ws), .i_block_value(blk), .i_gate(gate), .o_drive_active(act),
		.o_drive_on(on), .o_level_12v(lvl), .o_drive_state_feedback(fb), .o_fault_active(fa));
	task automatic results();
		$display("Checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic e, input logic a);
		n_tests++;
		if (a !== e) begin
			error_cnt++;
			$display("Error at %0t: output mismatch", $time);
		end
	endtask
	// Five cycles cover both pipeline stages plus a slow sender.
	task automatic go(input logic [15:0] v, input logic e);
		@(posedge clk);
		cfg <= b;
		gate <= g;
		val <= v;
		repeat (5) @(posedge clk) #1;
		chk(e, on);
	endtask
	task automatic flip(input logic e, output int k);
		for (k = 0; k < 20 && on !== e; k++) @(posedge clk) #1;
		chk(e, on);
		if (on !== e) results();
	endtask
	task automatic t_latch();
		go(16'h0000, 1'b0);
		chk(1'b0, lvl);
		chk(1'b1, act);
		go(16'h0002, 1'b1);
		go(16'h0000, 1'b1);
		go(16'h0003, 1'b0);
		$display("latch done");
	endtask
	task automatic t_fault();
		b.polarity = POL_NORMAL;
		b.fault_state = 1'b1;
		g.override_fault = 1'b1;
		go(16'h0000, 1'b1);
		chk(1'b1, fa);
		@(posedge clk);
		fmw <= 1'b1;
		b.fault_state = 1'b0;
		go(16'h0000, 1'b1);
		b.fault_mode = FAULT_MODE_PREDEFINED;
		g.enable_fault = 1'b1;
		go(16'h0001, 1'b0);
		g = '{enable: 1'b1, default: 1'b0};
		$display("fault done");
	endtask
	task automatic t_basic();
		b.polarity = POL_INVERSE;
		b.on_level_select = ON_LEVEL_12V;
		go(16'h0100, 1'b0);
		chk(1'b1, lvl);
		go(16'h0000, 1'b1);
		b.polarity = POL_NORMAL;
		go(16'h8000, 1'b1);
		// A frozen block must ignore the control change until the enable returns.
		@(posedge clk);
		ce <= 1'b0;
		val <= 16'h0000;
		repeat (5) @(posedge clk) #1;
		chk(1'b1, on);
		@(posedge clk);
		ce <= 1'b1;
		repeat (5) @(posedge clk) #1;
		chk(1'b0, on);
		g.enable = 1'b0;
		go(16'h0001, 1'b0);
		g = '{override_active: 1'b1, override_value: 1'b1, enable: 1'b1, default: 1'b0};
		go(16'h0000, 1'b1);
		g.override_active = 1'b0;
		b.control_source_select = CONTROL_SOURCE_NETWORK;
		b.control_number = 2'h3;
		go(16'h0004, 1'b1);
		chk(1'b1, fb);
		go(16'h0003, 1'b0);
		b.control_number = 2'h1;
		go(16'h0003, 1'b1);
		b.output_type_select = 16'h000a;
		go(16'h0004, 1'b0);
		chk(1'b0, act);
		chk(1'b0, fb);
		$display("basic done");
	endtask
	task automatic t_mode();
		b = '{output_type_select: OUTPUT_TYPE_DIGITAL, polarity: POL_BLINK, blink_rate_ms: 16'h1, default: '0};
		go(16'h0000, 1'b0);
		@(posedge clk);
		val <= 16'h0001;
		flip(1'b1, n);
		flip(1'b0, n);
		chk(1'b1, n == 4);
		b = '{output_type_select: OUTPUT_TYPE_DIGITAL, analog_control: 1'b1, control_min: 16'h000a,
			control_max: 16'h0014, default: '0};
		go(16'h0014, 1'b1);
		go(16'h000f, 1'b1);
		go(16'h000a, 1'b0);
		go(16'h000f, 1'b0);
		$display("mode done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_latch();
		t_fault();
		slow = 1'b1;
		t_basic();
		t_mode();
		results();
	end
endmodule
